/* src/twm_ctl_regs.svh */
/*
 * Register offsets, field positions and reset values of the two-wire
 * master control slice. Assumes byte addressing on a 32-bit APB.
 */
`ifndef TWM_CTL_REGS_SVH
`define TWM_CTL_REGS_SVH

`define OFS_INTERRUPT_LEVEL 12'h300
`define OFS_INTERRUPT_SET 12'h304
`define OFS_INTERRUPT_DISABLE 12'h308
`define OFS_EVENT_STATUS 12'h310
`define OFS_ERROR_SOURCE 12'h4C4
`define OFS_PERIPHERAL_ENABLE 12'h500

`define BIT_HALTED 0
`define BIT_ERROR 1
`define BIT_PAUSED 9
`define BIT_RX_BEGAN 19
`define BIT_TX_BEGAN 20
`define BIT_FINAL_RX 23
`define BIT_FINAL_TX 24

`define BIT_OVERRUN 0
`define BIT_ADDR_REFUSED 1
`define BIT_DATA_REFUSED 2

`define EVENT_MASK 32'h01980203
`define ERROR_MASK 32'h00000007
`define ENABLE_WIDTH 4
`define ENABLE_ON 4'h6
`define ENABLE_OFF 4'h0
`define RESET_ZERO 32'h00000000

`endif

/* src/twm_ctl_pkg.sv */
/*
 * Types shared by the two-wire master control slice.
 * Assumes the register header is included by the user.
 */
package twm_ctl_pkg;
   typedef logic [31:0] word_t;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ACCESS = 2'b01
   } apb_state_e;
endpackage

/* src/twm_sticky.sv */
/*
 * Bank of sticky write-one-to-clear bits; a set wins over a clear.
 * Assumes set and clear pulses come from the same clock domain.
 */
`timescale 1ns/1ps
module twm_sticky
#(
   parameter int WIDTH = 32
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_set,
   input wire logic [WIDTH-1:0] i_clr,
   output logic [WIDTH-1:0] o_bits
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
               o_bits[g] <= 1'b0;
            else if (i_set[g])
               o_bits[g] <= 1'b1;
            else if (i_clr[g])
               o_bits[g] <= 1'b0;
         end
      end
   endgenerate
endmodule // twm_sticky

/* src/twm_sync.sv */
/*
 * Two-flop synchroniser for a bank of asynchronous levels.
 * Assumes inputs change no faster than a few clocks.
 */
`timescale 1ns/1ps
module twm_sync
#(
   parameter int WIDTH = 8
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_q <= '0;
         o_sync <= '0;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule // twm_sync

/* src/twm_ctl.sv */
/*
 * Control and status slice of a two-wire master: interrupt enable
 * set/disable, event status, error source and peripheral enable,
 * reached over APB. Assumes the transfer engine drives the event
 * pulses from its own domain (they are resynchronised here as levels
 * that pulse high for at least two clocks and produce one edge each).
 */
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "twm_ctl_regs.svh"
module twm_ctl
   import twm_ctl_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic I_HALTED_EVENT,
   input wire logic I_PAUSED_EVENT,
   input wire logic I_RECEIVE_BEGAN_EVENT,
   input wire logic I_TRANSMIT_BEGAN_EVENT,
   input wire logic I_FINAL_RECEIVE_EVENT,
   input wire logic I_FINAL_TRANSMIT_EVENT,
   input wire logic I_OVERRUN,
   input wire logic I_ADDRESS_REFUSED,
   input wire logic I_DATA_REFUSED,
   output logic O_MASTER_ON,
   output logic O_IRQ
);
   // -----------------------------------------------------------------
   // event inputs: sync then edge detect
   // -----------------------------------------------------------------
   localparam int NEV = 9;
   // positions in the event vector; the error causes sit at the top
   localparam int EV_HALTED = 0;
   localparam int EV_PAUSED = 1;
   localparam int EV_RX_BEGAN = 2;
   localparam int EV_TX_BEGAN = 3;
   localparam int EV_FINAL_RX = 4;
   localparam int EV_FINAL_TX = 5;
   localparam int EV_OVERRUN = 6;
   localparam int EV_ADDR_REFUSED = 7;
   localparam int EV_DATA_REFUSED = 8;
   logic [NEV-1:0] ev_raw;
   logic [NEV-1:0] ev_sync;
   logic [NEV-1:0] ev_prev_q;
   logic [NEV-1:0] ev_rise;

   always_comb
   begin
      ev_raw = '0;
      ev_raw[EV_HALTED] = I_HALTED_EVENT;
      ev_raw[EV_PAUSED] = I_PAUSED_EVENT;
      ev_raw[EV_RX_BEGAN] = I_RECEIVE_BEGAN_EVENT;
      ev_raw[EV_TX_BEGAN] = I_TRANSMIT_BEGAN_EVENT;
      ev_raw[EV_FINAL_RX] = I_FINAL_RECEIVE_EVENT;
      ev_raw[EV_FINAL_TX] = I_FINAL_TRANSMIT_EVENT;
      ev_raw[EV_OVERRUN] = I_OVERRUN;
      ev_raw[EV_ADDR_REFUSED] = I_ADDRESS_REFUSED;
      ev_raw[EV_DATA_REFUSED] = I_DATA_REFUSED;
   end

   twm_sync #(.WIDTH(NEV)) u_sync
   (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_async(ev_raw),
      .o_sync(ev_sync)
   );

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
         ev_prev_q <= '0;
      else
         ev_prev_q <= ev_sync;
   end

   // events are only counted while the master is switched on
   assign ev_rise = ev_sync & ~ev_prev_q & {NEV{O_MASTER_ON}};

   // -----------------------------------------------------------------
   // apb access decode
   // -----------------------------------------------------------------
   apb_state_e state_q;
   logic wr_stb;
   logic rd_stb;
   logic hit;
   logic rd_take;
   logic wr_err;
   logic wr_evt;
   logic wr_en;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `OFS_INTERRUPT_LEVEL)
               || (a == `OFS_INTERRUPT_SET)
               || (a == `OFS_INTERRUPT_DISABLE)
               || (a == `OFS_EVENT_STATUS)
               || (a == `OFS_ERROR_SOURCE)
               || (a == `OFS_PERIPHERAL_ENABLE);
   endfunction

   // address match only: the strobe carries the bus qualifiers, so no
   // hidden read of a module signal escapes a continuous assign
   function automatic logic wr_to(input logic [11:0] a,
                                  input logic [11:0] ofs);
      wr_to = (a == ofs);
   endfunction

   assign hit = is_mapped(PADDR);
   // pready is registered so the access phase always lasts two cycles
   assign wr_stb = PSEL && PENABLE && PWRITE && PREADY;
   assign rd_stb = PSEL && !PENABLE;
   assign rd_take = rd_stb && !PWRITE;
   assign wr_err = wr_stb && wr_to(PADDR, `OFS_ERROR_SOURCE);
   assign wr_evt = wr_stb && wr_to(PADDR, `OFS_EVENT_STATUS);
   assign wr_en = wr_stb && wr_to(PADDR, `OFS_PERIPHERAL_ENABLE);

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
         state_q <= ST_IDLE;
      else
         unique case (state_q)
            ST_IDLE:
               if (PSEL && PENABLE)
                  state_q <= ST_ACCESS;
            ST_ACCESS:
               state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
   end

   // fixed single wait state keeps the decode off the access edge
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY <= PSEL && PENABLE && (state_q == ST_IDLE);
         PSLVERR <= PSEL && PENABLE && (state_q == ST_IDLE) && !hit;
      end
   end

   // -----------------------------------------------------------------
   // interrupt enables
   // -----------------------------------------------------------------
   word_t inten_q;
   logic do_set;
   logic do_clr;
   logic do_lvl;

   assign do_set = wr_stb && wr_to(PADDR, `OFS_INTERRUPT_SET);
   assign do_clr = wr_stb && wr_to(PADDR, `OFS_INTERRUPT_DISABLE);
   assign do_lvl = wr_stb && wr_to(PADDR, `OFS_INTERRUPT_LEVEL);

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
         inten_q <= `RESET_ZERO;
      else if (do_lvl)
         inten_q <= PWDATA & `EVENT_MASK;
      else if (do_set)
         inten_q <= inten_q | (PWDATA & `EVENT_MASK);
      else if (do_clr)
         inten_q <= inten_q & ~(PWDATA & `EVENT_MASK);
   end

   // -----------------------------------------------------------------
   // error source flags
   // -----------------------------------------------------------------
   word_t err_set;
   word_t err_clr;
   word_t err_bits;

   always_comb
   begin
      err_set = `RESET_ZERO;
      err_set[`BIT_OVERRUN] = ev_rise[EV_OVERRUN];
      err_set[`BIT_ADDR_REFUSED] = ev_rise[EV_ADDR_REFUSED];
      err_set[`BIT_DATA_REFUSED] = ev_rise[EV_DATA_REFUSED];
   end

   // write-one clears; set wins in the same cycle
   assign err_clr = wr_err
                    ? (PWDATA & `ERROR_MASK) : `RESET_ZERO;

   twm_sticky #(.WIDTH(32)) u_err
   (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_set(err_set),
      .i_clr(err_clr),
      .o_bits(err_bits)
   );

   // -----------------------------------------------------------------
   // event status
   // -----------------------------------------------------------------
   word_t evt_set;
   word_t evt_clr;
   word_t evt_bits;

   always_comb
   begin
      evt_set = `RESET_ZERO;
      evt_set[`BIT_HALTED] = ev_rise[EV_HALTED];
      evt_set[`BIT_PAUSED] = ev_rise[EV_PAUSED];
      evt_set[`BIT_RX_BEGAN] = ev_rise[EV_RX_BEGAN];
      evt_set[`BIT_TX_BEGAN] = ev_rise[EV_TX_BEGAN];
      evt_set[`BIT_FINAL_RX] = ev_rise[EV_FINAL_RX];
      evt_set[`BIT_FINAL_TX] = ev_rise[EV_FINAL_TX];
      evt_set[`BIT_ERROR] = |ev_rise[EV_DATA_REFUSED:EV_OVERRUN];
   end

   assign evt_clr = wr_evt
                    ? (PWDATA & `EVENT_MASK) : `RESET_ZERO;

   twm_sticky #(.WIDTH(32)) u_evt
   (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_set(evt_set),
      .i_clr(evt_clr),
      .o_bits(evt_bits)
   );

   // -----------------------------------------------------------------
   // peripheral enable
   // -----------------------------------------------------------------
   logic [`ENABLE_WIDTH-1:0] enable_q;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
         enable_q <= `ENABLE_OFF;
      else if (wr_en)
         enable_q <= PWDATA[`ENABLE_WIDTH-1:0];
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
         O_MASTER_ON <= 1'b0;
      else
         O_MASTER_ON <= (enable_q == `ENABLE_ON);
   end

   // -----------------------------------------------------------------
   // interrupt output
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
         O_IRQ <= 1'b0;
      else
         // level, so it stands until software clears the cause or its enable
         O_IRQ <= |(evt_bits & inten_q);
   end

   // -----------------------------------------------------------------
   // read data, captured in the setup cycle
   // -----------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
         PRDATA <= `RESET_ZERO;
      else if (rd_take)
      begin
         unique case (PADDR)
            `OFS_INTERRUPT_LEVEL,
            `OFS_INTERRUPT_SET,
            `OFS_INTERRUPT_DISABLE:
               PRDATA <= inten_q;
            `OFS_EVENT_STATUS:
               PRDATA <= evt_bits;
            `OFS_ERROR_SOURCE:
               PRDATA <= err_bits & `ERROR_MASK;
            `OFS_PERIPHERAL_ENABLE:
               PRDATA <= {{(32-`ENABLE_WIDTH){1'b0}}, enable_q};
            default:
               PRDATA <= `RESET_ZERO;
         endcase
      end
   end
endmodule // twm_ctl

/* sim/twm_ctl_properties.sv */
/* Port-level checks of the two-wire master control slice.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
`include "twm_ctl_regs.svh"
module twm_ctl_properties
(
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic O_MASTER_ON,
   input wire logic O_IRQ
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   logic en_wr;
   assign en_wr = PSEL && PENABLE && PREADY && PWRITE
      && PADDR == `OFS_PERIPHERAL_ENABLE;
   sequence wr_at(a);
      PSEL && PENABLE && PREADY && PWRITE && PADDR == a;
   endsequence
   chk_one_wait: assert property ($rose(PENABLE) && PSEL |=> PREADY)
      else $error("ready late");
   chk_ready_once: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   chk_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   chk_err_rdata: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("error read not zero");
   chk_on_six: assert property (wr_at(`OFS_PERIPHERAL_ENABLE) ##0
      PWDATA[3:0] == `ENABLE_ON |-> ##2 O_MASTER_ON)
      else $error("master not on");
   chk_off_other: assert property (wr_at(`OFS_PERIPHERAL_ENABLE) ##0
      PWDATA[3:0] != `ENABLE_ON |-> ##2 !O_MASTER_ON)
      else $error("master not off");
   chk_on_hold: assert property (!en_wr && !$past(en_wr)
      |=> $stable(O_MASTER_ON))
      else $error("master changed alone");
   chk_mask_irq: assert property (wr_at(`OFS_INTERRUPT_DISABLE) ##0
      PWDATA == `EVENT_MASK |-> ##2 !O_IRQ)
      else $error("irq not masked");
endmodule // twm_ctl_properties

bind twm_ctl twm_ctl_properties twm_ctl_properties_i
(
   .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .O_MASTER_ON(O_MASTER_ON), .O_IRQ(O_IRQ)
);

/* sim/twm_evt_src.sv */
/* Model of the transfer engine and slave side: event levels.
   Assumes the caller starts one event at a time. */
`timescale 1ns/1ps
module twm_evt_src
(
   input wire logic i_clk,
   output logic [8:0] o_ev
);
   initial o_ev = 9'h000;
   // held 3 clocks each way, above the 2-clock minimum of the sync
   task automatic fire(input int k);
      @(posedge i_clk);
      o_ev[k] <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ev[k] <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
endmodule // twm_evt_src

/* sim/twm_ctl_tb.sv */
/* Self-checking bench of the two-wire master control slice.
   Assumes the event source model and the bound checker. */
`timescale 1ns/1ps
`include "twm_ctl_regs.svh"
module twm_ctl_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, on, irq;
   logic [8:0] ev;
   logic [32:0] exp_q[$];
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   integer seed = 32'hA121;
   logic [31:0] r;
   int pos[9] = '{0, 9, 19, 20, 23, 24, 1, 1, 1};
   twm_ctl twm_ctl_i
   (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .I_HALTED_EVENT(ev[0]),
      .I_PAUSED_EVENT(ev[1]), .I_RECEIVE_BEGAN_EVENT(ev[2]),
      .I_TRANSMIT_BEGAN_EVENT(ev[3]), .I_FINAL_RECEIVE_EVENT(ev[4]),
      .I_FINAL_TRANSMIT_EVENT(ev[5]), .I_OVERRUN(ev[6]),
      .I_ADDRESS_REFUSED(ev[7]), .I_DATA_REFUSED(ev[8]),
      .O_MASTER_ON(on), .O_IRQ(irq)
   );
   twm_evt_src twm_evt_src_i (.i_clk(clk), .o_ev(ev));
   // ----------------------------------------
   // bus tasks and scoreboard
   // ----------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      num_checks++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("ERROR %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   function automatic logic unmapped(input logic [11:0] a);
      return !(a inside {`OFS_INTERRUPT_LEVEL, `OFS_INTERRUPT_SET,
         `OFS_INTERRUPT_DISABLE, `OFS_EVENT_STATUS, `OFS_ERROR_SOURCE,
         `OFS_PERIPHERAL_ENABLE});
   endfunction
   task automatic xfer(input int w, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] e);
      exp_q.push_back({unmapped(a), (w != 0) ? 32'h0 : e});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= (w != 0);
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
      forever #20 clk = ~clk;
   // read data sampled at the edge that completes the access
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (psel && penable && pready === 1'b1)
         check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
      if (cyc == 6000)
      begin
         error_cnt++;
         close_out();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      xfer(0, `OFS_INTERRUPT_DISABLE, 0, `RESET_ZERO);
      xfer(0, `OFS_ERROR_SOURCE, 0, `RESET_ZERO);
      xfer(0, `OFS_PERIPHERAL_ENABLE, 0, `RESET_ZERO);
      r = $random(seed);
      xfer(1, `OFS_INTERRUPT_SET, r, 0);
      xfer(0, `OFS_INTERRUPT_DISABLE, 0, r & `EVENT_MASK);
      xfer(1, `OFS_INTERRUPT_DISABLE, 32'h00180001, 0);
      xfer(0, `OFS_INTERRUPT_SET, 0, r & `EVENT_MASK & ~32'h00180001);
      r = $random(seed);
      xfer(1, `OFS_INTERRUPT_LEVEL, r, 0);
      xfer(0, `OFS_INTERRUPT_DISABLE, 0, r & `EVENT_MASK);
      twm_evt_src_i.fire(6);
      xfer(0, `OFS_ERROR_SOURCE, 0, `RESET_ZERO);
      r = {28'h0, 4'($random(seed))};
      if (r == 32'h6)
         r = 32'h7;
      xfer(1, `OFS_PERIPHERAL_ENABLE, r, 0);
      xfer(0, `OFS_PERIPHERAL_ENABLE, 0, r);
      check({32'h0, on}, 33'h0);
      xfer(1, `OFS_PERIPHERAL_ENABLE, 32'(`ENABLE_ON), 0);
      xfer(0, `OFS_PERIPHERAL_ENABLE, 0, 32'h6);
      check({32'h0, on}, 33'h1);
      xfer(1, `OFS_INTERRUPT_SET, `EVENT_MASK, 0);
      for (int k = 0; k < 9; k++)
      begin
         twm_evt_src_i.fire(k);
         xfer(0, `OFS_EVENT_STATUS, 0, 32'h1 << pos[k]);
         if (k > 5)
         begin
            xfer(0, `OFS_ERROR_SOURCE, 0, 32'h1 << (k - 6));
            xfer(1, `OFS_ERROR_SOURCE, 32'h1 << (k - 6), 0);
         end
         check({32'h0, irq}, 33'h1);
         xfer(1, `OFS_EVENT_STATUS, 32'h1 << pos[k], 0);
      end
      xfer(0, `OFS_ERROR_SOURCE, 0, `RESET_ZERO);
      check({32'h0, irq}, 33'h0);
      twm_evt_src_i.fire(8);
      xfer(1, `OFS_INTERRUPT_DISABLE, `EVENT_MASK, 0);
      xfer(0, `OFS_INTERRUPT_SET, 0, `RESET_ZERO);
      check({32'h0, irq}, 33'h0);
      xfer(0, `OFS_EVENT_STATUS, 0, 32'h2);
      xfer(0, 12'h200, 0, 32'h0);
      xfer(1, 12'h204, 32'hFFFFFFFF, 0);
      // mid-run reset with the master on must switch it off again
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      check({32'h0, on}, 33'h0);
      xfer(0, `OFS_PERIPHERAL_ENABLE, 0, `RESET_ZERO);
      close_out();
   end
endmodule // twm_ctl_tb
